// ==== design/output_turn_on_off_sequencer.sv ====
// per-channel output turn-on/turn-off wait sequencer with synchronization offset
//
// Operation
// - auto source: offset is peak of installed channels
// - manual source: use last programmed sync offset
// - source resets to auto, readable back
// - writing source forces every channel off
// - source survives the instrument reset command
// - read-only peak required offset of installed channels
// - all channels sequence; offset keeps turn-ons aligned
// - manual offset is reference for turn-on waits
// - off request: stay on until fall wait ends
// - fall wait for state/range changes, not protection
// - on request: stay off until rise wait ends
// - rise wait on every off-to-on, incl. protection clear
// - waits programmable zero to 1023 seconds
// - resolution steps by decades from 100 ns
// - query reports current, minimum or maximum wait
// - same-type channels timed exactly by rise waits
// - type skew fixed per channel, repeatable
// - coupled channels switch together, also by pin
// - manual offset 0-1.023 s, coupled channels only
`timescale 1ns/1ns
module output_turn_on_off_sequencer import seq_pkg::*; #(
  parameter int unsigned DECADE_RATIO = DECADE_RATIO_DEF,
  parameter int unsigned OFFSET_UNIT_CYCLES = OFFSET_UNIT_CYCLES_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_inst_reset,
  input wire logic [NCHAN-1:0] i_wait_wr_rise,
  input wire logic [NCHAN-1:0] i_wait_wr_fall,
  input wire logic [MANT_W-1:0] i_wait_mant,
  input wire logic [DEC_W-1:0] i_wait_dec,
  input wire logic i_src_wr,
  input wire logic i_src_manual,
  input wire logic i_offset_wr,
  input wire logic [OFS_W-1:0] i_offset_ms,
  input wire logic [NCHAN-1:0] i_chan_present,
  input wire logic [NCHAN-1:0][OFS_W-1:0] i_chan_offset_req,
  input wire logic i_couple_en,
  input wire logic [NCHAN-1:0] i_couple_mask,
  input wire logic i_pin_on,
  input wire logic i_pin_off,
  input wire logic [NCHAN-1:0] i_on_req,
  input wire logic [NCHAN-1:0] i_off_req,
  input wire logic [NCHAN-1:0] i_range_off,
  input wire logic [NCHAN-1:0] i_prot_clear,
  input wire logic [NCHAN-1:0] i_prot_trip,
  input wire logic [CHAN_W-1:0] i_query_chan,
  input wire logic i_query_fall,
  input wire logic [1:0] i_query_sel,
  output logic [NCHAN-1:0] o_out_en,
  output logic [NCHAN-1:0] o_busy,
  output logic o_sync_offset_source,
  output logic [OFS_W-1:0] o_sync_offset,
  output logic [OFS_W-1:0] o_required_offset_peak,
  output logic [WAIT_W-1:0] o_query_wait
);

  typedef struct packed {
    chan_state_type [NCHAN-1:0] st;
    logic [NCHAN-1:0][WAIT_W-1:0] rise;
    logic [NCHAN-1:0][WAIT_W-1:0] fall;
    logic [NCHAN-1:0][PRE_W-1:0] pre;
    logic [NCHAN-1:0][MANT_W-1:0] cnt;
    logic [NCHAN-1:0] out;
    offset_source_type src;
    logic [OFS_W-1:0] ofs;
    logic [OFS_W-1:0] peak;
    logic [WAIT_W-1:0] qry;
  } seq_state_type;

  localparam logic [PRE_W-1:0] OFFSET_LIM = OFFSET_UNIT_CYCLES[PRE_W-1:0];

  seq_state_type cur;
  seq_state_type next_cur;

  // cycles per step of a decade: TICK_CYCLES * ratio^decade
  function automatic logic [PRE_W-1:0] decade_lim(input logic [DEC_W-1:0] d);
    int unsigned v;
    v = TICK_CYCLES;
    for (int i = 0; i < DEC_COUNT - 1; i++) begin
      if (i < int'(d)) begin
        v = v * DECADE_RATIO;
      end
    end
    return v[PRE_W-1:0];
  endfunction

  always_comb begin
    logic [OFS_W-1:0] peak_v;
    logic [OFS_W-1:0] eff;
    logic [OFS_W-1:0] pad;
    logic [NCHAN-1:0] cpl;
    logic [NCHAN-1:0] on_c;
    logic [NCHAN-1:0] off_c;
    logic grp_on;
    logic grp_off;
    logic force_off;
    logic do_tick;
    logic [PRE_W-1:0] lim;
    logic [WAIT_W-1:0] sel_wait;
    peak_v = '0;
    eff = '0;
    pad = '0;
    cpl = '0;
    on_c = '0;
    off_c = '0;
    grp_on = 1'b0;
    grp_off = 1'b0;
    force_off = 1'b0;
    do_tick = 1'b0;
    lim = '0;
    sel_wait = '0;
    next_cur = cur;

    for (int c = 0; c < NCHAN; c++) begin
      if (i_chan_present[c] && i_chan_offset_req[c] > peak_v) begin
        peak_v = i_chan_offset_req[c];
      end
    end
    next_cur.peak = peak_v;

    // source and manual offset are untouched by the instrument reset command
    if (i_src_wr) begin
      next_cur.src = i_src_manual ? SRC_MANUAL : SRC_AUTO;
    end
    if (i_offset_wr) begin
      next_cur.ofs = i_offset_ms;
    end
    force_off = i_src_wr | i_offset_wr;

    // coupled group follows any member request or the couple pins
    cpl = i_couple_en ? i_couple_mask : '0;
    grp_on = (|cpl) & (i_pin_on | (|(i_on_req & cpl)));
    grp_off = (|cpl) & (i_pin_off | (|((i_off_req | i_range_off) & cpl)));
    on_c = i_on_req | i_prot_clear | ({NCHAN{grp_on}} & cpl);
    off_c = i_off_req | i_range_off | ({NCHAN{grp_off}} & cpl);

    for (int c = 0; c < NCHAN; c++) begin
      do_tick = 1'b0;
      if (i_wait_wr_rise[c]) begin
        next_cur.rise[c] = {i_wait_dec, i_wait_mant};
      end
      if (i_wait_wr_fall[c]) begin
        next_cur.fall[c] = {i_wait_dec, i_wait_mant};
      end

      // pad brings each channel up to its offset reference: the manual offset if coupled in manual mode, else the peak
      if (cur.src == SRC_MANUAL && cpl[c]) begin
        eff = cur.ofs;
      end else begin
        eff = cur.peak;
      end
      pad = (eff > i_chan_offset_req[c]) ? OFS_W'(eff - i_chan_offset_req[c]) : '0;

      case (cur.st[c])
        ST_OFF: begin
          next_cur.out[c] = 1'b0;
          if (on_c[c]) begin
            next_cur.st[c] = ST_PAD;
            next_cur.cnt[c] = pad;
            next_cur.pre[c] = '0;
          end
        end
        ST_PAD: begin
          lim = OFFSET_LIM;
          if (off_c[c]) begin
            next_cur.st[c] = ST_OFF;
          end else if (cur.cnt[c] == '0) begin
            next_cur.st[c] = ST_RISE;
            next_cur.cnt[c] = cur.rise[c][MANT_W-1:0];
            next_cur.pre[c] = '0;
          end else begin
            do_tick = 1'b1;
          end
        end
        ST_RISE: begin
          lim = decade_lim(cur.rise[c][WAIT_W-1:MANT_W]);
          if (off_c[c]) begin
            next_cur.st[c] = ST_OFF;
          end else if (cur.cnt[c] == '0) begin
            next_cur.st[c] = ST_ON;
            next_cur.out[c] = 1'b1;
          end else begin
            do_tick = 1'b1;
          end
        end
        ST_ON: begin
          next_cur.out[c] = 1'b1;
          if (off_c[c]) begin
            next_cur.st[c] = ST_FALL;
            next_cur.cnt[c] = cur.fall[c][MANT_W-1:0];
            next_cur.pre[c] = '0;
          end
        end
        ST_FALL: begin
          lim = decade_lim(cur.fall[c][WAIT_W-1:MANT_W]);
          if (on_c[c]) begin
            next_cur.st[c] = ST_ON;
          end else if (cur.cnt[c] == '0) begin
            next_cur.st[c] = ST_OFF;
            next_cur.out[c] = 1'b0;
          end else begin
            do_tick = 1'b1;
          end
        end
        default: begin
          next_cur.st[c] = ST_OFF;
          next_cur.out[c] = 1'b0;
        end
      endcase

      if (do_tick) begin
        if (cur.pre[c] >= lim - PRE_W'(1)) begin
          next_cur.pre[c] = '0;
          next_cur.cnt[c] = cur.cnt[c] - MANT_W'(1);
        end else begin
          next_cur.pre[c] = cur.pre[c] + PRE_W'(1);
        end
      end

      if (i_inst_reset) begin
        next_cur.rise[c] = WAIT_RESET;
        next_cur.fall[c] = WAIT_RESET;
      end
      // protection bypasses the fall wait
      if (i_prot_trip[c] || force_off || i_inst_reset) begin
        next_cur.st[c] = ST_OFF;
        next_cur.out[c] = 1'b0;
        next_cur.cnt[c] = '0;
        next_cur.pre[c] = '0;
      end
    end

    sel_wait = i_query_fall ? cur.fall[i_query_chan] : cur.rise[i_query_chan];
    // min and max are the limits of the wait range, not a channel's setting
    case (i_query_sel)
      Q_MIN: begin
        next_cur.qry = WAIT_MIN;
      end
      Q_MAX: begin
        next_cur.qry = WAIT_MAX;
      end
      default: begin
        next_cur.qry = sel_wait;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  always_comb begin
    for (int c = 0; c < NCHAN; c++) begin
      o_busy[c] = (cur.st[c] == ST_PAD) || (cur.st[c] == ST_RISE) || (cur.st[c] == ST_FALL);
    end
  end

  assign o_out_en = cur.out;
  assign o_sync_offset_source = cur.src;
  assign o_sync_offset = cur.ofs;
  assign o_required_offset_peak = cur.peak;
  assign o_query_wait = cur.qry;

endmodule

// ==== design/seq_pkg.sv ====
// constants and types shared by the output turn-on/turn-off sequencer
package seq_pkg;

  localparam int unsigned NCHAN = 4;
  localparam int unsigned CHAN_W = 2;

  // a wait is a 10-bit mantissa times a decade step, the step being 100 ns * 10^decade
  localparam int unsigned MANT_W = 10;
  localparam int unsigned DEC_W = 3;
  localparam int unsigned WAIT_W = MANT_W + DEC_W;
  localparam int unsigned DEC_COUNT = 8;
  localparam logic [MANT_W-1:0] MANT_MAX = 10'h3FF;
  localparam logic [DEC_W-1:0] DEC_MAX = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_MIN = 13'h0000;
  localparam logic [WAIT_W-1:0] WAIT_MAX = {DEC_MAX, MANT_MAX};
  localparam logic [WAIT_W-1:0] WAIT_RESET = 13'h0000;

  // clock and the base tick
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS = 100;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DECADE_RATIO_DEF = 10;

  // offsets are counted in whole milliseconds, 0 to 1023
  localparam int unsigned OFS_W = 10;
  localparam int unsigned OFFSET_UNIT_NS = 1000000;
  localparam int unsigned OFFSET_UNIT_CYCLES_DEF = OFFSET_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [OFS_W-1:0] OFS_RESET = 10'h000;

  // prescaler must hold 10^7 cycles
  localparam int unsigned PRE_W = 24;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PAD = 3'b001,
    ST_RISE = 3'b010,
    ST_ON = 3'b011,
    ST_FALL = 3'b100
  } chan_state_type;

  typedef enum logic {
    SRC_AUTO = 1'b0,
    SRC_MANUAL = 1'b1
  } offset_source_type;

  typedef enum logic [1:0] {
    Q_CURRENT = 2'b00,
    Q_MIN = 2'b01,
    Q_MAX = 2'b10
  } query_sel_type;

endpackage

// ==== testbench/seq_asserts.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
module seq_asserts import seq_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_inst_reset,
  input wire logic i_src_wr,
  input wire logic i_src_manual,
  input wire logic i_offset_wr,
  input wire logic [OFS_W-1:0] i_offset_ms,
  input wire logic [NCHAN-1:0] i_chan_present,
  input wire logic [NCHAN-1:0][OFS_W-1:0] i_chan_offset_req,
  input wire logic [NCHAN-1:0] i_prot_trip,
  input wire logic [1:0] i_query_sel,
  input wire logic [NCHAN-1:0] o_out_en,
  input wire logic [NCHAN-1:0] o_busy,
  input wire logic o_sync_offset_source,
  input wire logic [OFS_W-1:0] o_sync_offset,
  input wire logic [OFS_W-1:0] o_required_offset_peak,
  input wire logic [WAIT_W-1:0] o_query_wait
);
  logic [OFS_W-1:0] peak_exp;
  always_comb begin
    peak_exp = '0;
    for (int i = 0; i < NCHAN; i++) begin
      if (i_chan_present[i] && i_chan_offset_req[i] > peak_exp) begin
        peak_exp = i_chan_offset_req[i];
      end
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_src_taken: assert property (i_src_wr |=> o_sync_offset_source == $past(i_src_manual))
    else $error("source write not taken");
  a_src_forces_off: assert property (i_src_wr |=> o_out_en == '0)
    else $error("source write left an output on");
  a_src_kept: assert property (i_inst_reset && !i_src_wr |=> $stable(o_sync_offset_source))
    else $error("source lost on instrument reset");
  a_offset_taken: assert property (i_offset_wr |=> o_sync_offset == $past(i_offset_ms))
    else $error("manual offset not taken");
  a_trip_off: assert property (|i_prot_trip |=> (o_out_en & $past(i_prot_trip)) == '0)
    else $error("tripped output still on");
  a_peak_value: assert property (o_required_offset_peak == $past(peak_exp))
    else $error("peak offset wrong");
  a_on_after_wait: assert property (!(|(o_out_en & ~$past(o_out_en) & ~$past(o_busy))))
    else $error("output on without wait");
  a_query_max: assert property (i_query_sel == Q_MAX |=> o_query_wait == WAIT_MAX)
    else $error("max wait query wrong");
  a_query_min: assert property (i_query_sel == Q_MIN |=> o_query_wait == WAIT_MIN)
    else $error("min wait query wrong");
endmodule
bind output_turn_on_off_sequencer seq_asserts u_chk (.*);

// ==== testbench/tb.sv ====
// self-checking bench for the output turn-on/turn-off sequencer
`timescale 1ns/1ns
module tb;
  import seq_pkg::*;
  logic i_clk_sys, i_rst, i_inst_reset, i_src_wr, i_src_manual, i_offset_wr, i_couple_en, i_pin_on, i_pin_off;
  logic [3:0] i_wait_wr_rise, i_wait_wr_fall, i_chan_present, i_couple_mask, i_on_req, i_off_req;
  logic [3:0] i_range_off, i_prot_clear, i_prot_trip, o_out_en, o_busy;
  logic [9:0] i_wait_mant, i_offset_ms, o_sync_offset, o_required_offset_peak;
  logic [3:0][9:0] i_chan_offset_req;
  logic [2:0] i_wait_dec;
  logic [1:0] i_query_chan, i_query_sel;
  logic i_query_fall, o_sync_offset_source;
  logic [12:0] o_query_wait;
  int errors, n_compared;
  output_turn_on_off_sequencer #(.DECADE_RATIO(2), .OFFSET_UNIT_CYCLES(4)) dut (.*);
  always #50 i_clk_sys = ~i_clk_sys;
  task test_done;
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input int ch, input logic fall, input logic [12:0] v);
    @(negedge i_clk_sys);
    {i_wait_dec, i_wait_mant} = v;
    if (fall) i_wait_wr_fall[ch] = 1'b1;
    else i_wait_wr_rise[ch] = 1'b1;
    @(negedge i_clk_sys);
    i_wait_wr_fall = '0;
    i_wait_wr_rise = '0;
  endtask
  task cfg(input logic src, input logic man, input logic [9:0] ms);
    @(negedge i_clk_sys);
    {i_src_wr, i_src_manual, i_offset_wr, i_offset_ms} = {src, man, !src, ms};
    @(negedge i_clk_sys);
    {i_src_wr, i_offset_wr} = '0;
  endtask
  task query(input int ch, input logic fall, input logic [1:0] sel, input logic [12:0] e);
    @(negedge i_clk_sys);
    {i_query_chan, i_query_fall, i_query_sel} = {ch[1:0], fall, sel};
    @(negedge i_clk_sys);
    chk("query_wait", e, o_query_wait);
  endtask
  // kind 0 on, 1 off, 2 range off, 3 trip, 4 protection clear; e counts edges from the taking edge to the flip
  task turn(input int ch, input int kind, input logic [12:0] e);
    logic on;
    int k;
    on = (kind == 0 || kind == 4);
    @(negedge i_clk_sys);
    case (kind)
      0: i_on_req[ch] = 1'b1;
      1: i_off_req[ch] = 1'b1;
      2: i_range_off[ch] = 1'b1;
      3: i_prot_trip[ch] = 1'b1;
      default: i_prot_clear[ch] = 1'b1;
    endcase
    @(negedge i_clk_sys);
    {i_on_req, i_off_req, i_range_off, i_prot_trip, i_prot_clear} = '0;
    chk("busy", 13'(kind != 3), 13'(o_busy[ch]));
    k = 1;
    while (o_out_en[ch] !== on && k < 200) begin
      @(negedge i_clk_sys);
      k++;
    end
    chk("edges_to_switch", e, 13'(k));
    if (k == 200) test_done;
  endtask
  initial begin
    {i_clk_sys, i_inst_reset, i_src_wr, i_src_manual, i_offset_wr, i_couple_en, i_pin_on, i_pin_off} = '0;
    {i_wait_wr_rise, i_wait_wr_fall, i_couple_mask, i_on_req, i_off_req, i_range_off, i_prot_clear} = '0;
    {i_prot_trip, i_wait_mant, i_offset_ms, i_chan_offset_req, i_wait_dec, i_query_chan, i_query_sel} = '0;
    {i_query_fall, errors, n_compared} = '0;
    i_chan_present = 4'hF;
    i_rst = 1'b1;
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk("source", 13'h0000, o_sync_offset_source);
    query(0, 1'b0, 2'h0, 13'h0000);
    wr(0, 1'b0, 13'h0403);
    wr(0, 1'b1, 13'h0005);
    query(0, 1'b0, 2'h0, 13'h0403);
    query(0, 1'b1, 2'h1, 13'h0000);
    query(0, 1'b1, 2'h2, 13'h1FFF);
    turn(0, 0, 13'h0009);
    turn(0, 1, 13'h0007);
    turn(0, 0, 13'h0009);
    turn(0, 2, 13'h0007);
    turn(0, 0, 13'h0009);
    turn(0, 3, 13'h0001);
    turn(0, 4, 13'h0009);
    turn(1, 0, 13'h0003);
    i_chan_present = 4'hB;
    i_chan_offset_req[0] = 10'h002;
    i_chan_offset_req[2] = 10'h007;
    repeat (2) @(negedge i_clk_sys);
    chk("peak", 13'h0002, o_required_offset_peak);
    cfg(1'b1, 1'b0, 10'h000);
    chk("out_en", 13'h0000, o_out_en);
    turn(1, 0, 13'h000B);
    cfg(1'b1, 1'b1, 10'h000);
    cfg(1'b0, 1'b0, 10'h003);
    i_couple_en = 1'b1;
    i_couple_mask = 4'h1;
    chk("source", 13'h0001, o_sync_offset_source);
    turn(0, 0, 13'h000D);
    i_inst_reset = 1'b1;
    @(negedge i_clk_sys);
    i_inst_reset = 1'b0;
    chk("source", 13'h0001, o_sync_offset_source);
    chk("offset", 13'h0003, o_sync_offset);
    chk("out_en", 13'h0000, o_out_en);
    query(0, 1'b0, 2'h0, 13'h0000);
    test_done;
  end
endmodule
